// ===== design/ppm_pkg.sv
// Contract
// - port 1 bits 5,6,7 feed ext irq 0, ext irq 1, timer zero count
// - port 1 bits 0-4 are analog inputs; drive only with converter off
// - converter on: selected channel reads zero, analog pins never drive; verify mode still drives them
// - unused alternate inputs leave port 1 bits as plain port bits
// - port 0 five bits; bits 0-2 open drain, bits 3-4 pulled up
// - port 0 bit 4 carries pwm output when enabled, else port bit
// - port 3 eight bits with pull-ups; written 1 lets pin be input
// - part select 0 gives low byte, 1 gives high three bits
// - verify drives memory data on port 1; program takes port 1 data
// - output enable on port 0 bit 1 high selects verify mode
// - reset pin high two machine cycles resets the device
// - entry bits sampled on reset pin with crystal input as strobe
// - internal clock is crystal divided by two
// - idle halts cpu, keeps timers and irqs, stops converter and pwm
// - idle ends on enabled interrupt or hardware reset
// - power-down stops oscillator; only hardware reset leaves it
// - idle and power-down keep latched port data except pwm pin
package ppm_pkg;
  localparam int p0_width = 5;
  localparam int p1_width = 8;
  localparam int p3_width = 8;
  localparam int analog_count = 5;
  localparam int open_drain_count = 3;
  localparam int pwm_bit = 4;
  localparam int irq0_bit = 5;
  localparam int irq1_bit = 6;
  localparam int count_bit = 7;
  localparam int sel_bit = 0;
  localparam int oe_bit = 1;
  localparam int addr_width = 11;
  localparam int high_addr_bits = 3;
  localparam int entry_len = 10;
  localparam logic [9:0] entry_code = 10'h2a5;
  localparam int machine_cycle_clocks = 12;
  localparam int reset_machine_cycles = 2;
  localparam int reset_clocks = machine_cycle_clocks * reset_machine_cycles;
  localparam logic [4:0] p0_reset = 5'h1f;
  localparam logic [7:0] p1_reset = 8'hff;
  localparam logic [7:0] p3_reset = 8'hff;
  typedef enum logic [3:0] {
    ppm_run = 4'b0001,
    ppm_idle = 4'b0010,
    ppm_down = 4'b0100,
    ppm_prog = 4'b1000
  } ppm_mode_type;
endpackage : ppm_pkg

// ===== design/ppm_sync.sv
`timescale 1ns/100ps
module ppm_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  logic [width-1:0] stage;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= '0;
      dout <= '0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule : ppm_sync

// ===== design/ppm_entry.sv
`timescale 1ns/100ps
// shifts reset-pin bits on rising crystal edges, lsb first
module ppm_entry #(
  parameter logic [9:0] code = ppm_pkg::entry_code
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic armed,
  input wire logic strobe,
  input wire logic bit_in,
  output logic match
);
  logic [9:0] shift;
  always_ff @(posedge clk) begin
    if (rst || !armed) begin
      shift <= '0;
    end else if (strobe) begin
      shift <= {bit_in, shift[9:1]};
    end
  end
  assign match = armed && (shift == code);
endmodule : ppm_entry

// ===== design/ppm_top.sv
`timescale 1ns/100ps
module ppm_top #(
  parameter logic [9:0] entry_code = ppm_pkg::entry_code,
  parameter int reset_clocks = ppm_pkg::reset_clocks
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic crystal_in,
  input wire logic reset_pin,
  input wire logic [4:0] p0_in,
  output logic [4:0] p0_out,
  output logic [4:0] p0_oe_n,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe_n,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe_n,
  input wire logic p0_wr,
  input wire logic [4:0] p0_wdata,
  input wire logic p1_wr,
  input wire logic [7:0] p1_wdata,
  input wire logic p3_wr,
  input wire logic [7:0] p3_wdata,
  output logic [4:0] p0_read,
  output logic [7:0] p1_read,
  output logic [7:0] p3_read,
  input wire logic adc_enable,
  input wire logic [2:0] adc_channel,
  input wire logic pwm_enable,
  input wire logic pwm_level,
  input wire logic irq0_enable,
  input wire logic irq1_enable,
  input wire logic count_enable,
  input wire logic idle_request,
  input wire logic down_request,
  input wire logic irq_pending,
  input wire logic [7:0] mem_rdata,
  output logic ext_irq0_in,
  output logic ext_irq1_in,
  output logic timer_zero_count_in,
  output logic [10:0] prog_addr,
  output logic [7:0] prog_wdata,
  output logic prog_write,
  output logic prog_mode,
  output logic cpu_run,
  output logic periph_run,
  output logic analog_run,
  output logic osc_run,
  output logic internal_clock,
  output logic device_reset
);
  ////////////////////////////////////////////////////////////////////
  logic [4:0] p0_s;
  logic [7:0] p1_s;
  logic [7:0] p3_s;
  logic xtal_s;
  logic rstpin_s;
  logic xtal_d;
  logic xtal_rise;
  logic entry_match;
  logic armed;
  logic [5:0] rst_cnt;
  logic [4:0] p0_latch;
  logic [7:0] p1_latch;
  logic [7:0] p3_latch;
  logic [7:0] low_addr;
  logic [2:0] high_addr;
  logic prog_d;
  ppm_pkg::ppm_mode_type mode;
  ppm_pkg::ppm_mode_type next_mode;
  logic [4:0] next_p0_oe_n;
  logic [7:0] next_p1_oe_n;
  logic [7:0] next_p1_out;
  logic [7:0] next_p1_read;
  logic [4:0] next_p0_out;
  logic reset_now;

  ppm_sync #(.width(23)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({p0_in, p1_in, p3_in, crystal_in, reset_pin}),
    .dout({p0_s, p1_s, p3_s, xtal_s, rstpin_s})
  );

  ppm_entry #(.code(entry_code)) u_entry (
    .clk(clk),
    .rst(rst),
    .armed(armed),
    .strobe(xtal_rise),
    .bit_in(rstpin_s),
    .match(entry_match)
  );

  ////////////////////////////////////////////////////////////////////
  // crystal edge detect and divide by two
  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_d <= 1'b0;
      internal_clock <= 1'b0;
    end else begin
      xtal_d <= xtal_s;
      if (xtal_rise && mode != ppm_pkg::ppm_down) begin
        internal_clock <= ~internal_clock;
      end
    end
  end
  assign xtal_rise = xtal_s && !xtal_d;

  // reset pin qualification, counted on crystal edges
  always_ff @(posedge clk) begin
    if (rst || !rstpin_s) begin
      rst_cnt <= '0;
    end else if (xtal_rise && rst_cnt != 6'(reset_clocks)) begin
      rst_cnt <= rst_cnt + 6'h01;
    end
  end
  assign reset_now = rst_cnt == 6'(reset_clocks);

  always_ff @(posedge clk) begin
    if (rst) begin
      device_reset <= 1'b1;
    end else begin
      device_reset <= reset_now;
    end
  end

  // entry window opens once reset pin falls after a device reset
  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (reset_now) begin
      armed <= 1'b0;
    end else if (device_reset) begin
      armed <= 1'b1;
    end else if (mode == ppm_pkg::ppm_prog) begin
      armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power modes; only reset leaves power-down
  always_comb begin
    next_mode = mode;
    unique case (mode)
      ppm_pkg::ppm_run: begin
        if (entry_match) next_mode = ppm_pkg::ppm_prog;
        else if (down_request) next_mode = ppm_pkg::ppm_down;
        else if (idle_request) next_mode = ppm_pkg::ppm_idle;
      end
      ppm_pkg::ppm_idle: begin
        if (irq_pending) next_mode = ppm_pkg::ppm_run;
      end
      ppm_pkg::ppm_down: next_mode = ppm_pkg::ppm_down;
      ppm_pkg::ppm_prog: next_mode = ppm_pkg::ppm_prog;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || reset_now) begin
      mode <= ppm_pkg::ppm_run;
      cpu_run <= 1'b0;
      periph_run <= 1'b0;
      analog_run <= 1'b0;
      osc_run <= 1'b1;
      prog_mode <= 1'b0;
    end else begin
      mode <= next_mode;
      cpu_run <= next_mode == ppm_pkg::ppm_run;
      periph_run <= next_mode inside {ppm_pkg::ppm_run, ppm_pkg::ppm_idle};
      analog_run <= next_mode == ppm_pkg::ppm_run;
      osc_run <= next_mode != ppm_pkg::ppm_down;
      prog_mode <= next_mode == ppm_pkg::ppm_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port latches hold through idle and power-down; cpu writes gated
  always_ff @(posedge clk) begin
    if (rst || reset_now) begin
      p0_latch <= ppm_pkg::p0_reset;
      p1_latch <= ppm_pkg::p1_reset;
      p3_latch <= ppm_pkg::p3_reset;
    end else if (mode == ppm_pkg::ppm_run) begin
      if (p0_wr) p0_latch <= p0_wdata;
      if (p1_wr) p1_latch <= p1_wdata;
      if (p3_wr) p3_latch <= p3_wdata;
    end
  end

  // analog pins: converter on blocks drive except in verify, selected channel unreadable
  always_comb begin
    next_p1_oe_n = 8'hff;
    next_p1_out = 8'h00;
    next_p1_read = p1_s;
    for (int i = 0; i < ppm_pkg::p1_width; i++) begin
      // pull-up drives high through the output model when latch is 1
      next_p1_out[i] = p1_latch[i];
      next_p1_oe_n[i] = 1'b0;
      // enable, not run state, floats the pins, so idle leaves them untouched
      if (i < ppm_pkg::analog_count && adc_enable) begin
        next_p1_oe_n[i] = 1'b1;
        if (adc_channel == 3'(i)) next_p1_read[i] = 1'b0;
      end
    end
    if (mode == ppm_pkg::ppm_prog) begin
      next_p1_out = mem_rdata;
      next_p1_oe_n = p0_s[ppm_pkg::oe_bit] ? 8'h00 : 8'hff;
    end
  end

  always_comb begin
    next_p0_out = p0_latch;
    next_p0_oe_n = 5'h00;
    for (int i = 0; i < ppm_pkg::open_drain_count; i++) begin
      next_p0_oe_n[i] = p0_latch[i];
      next_p0_out[i] = 1'b0;
    end
    if (pwm_enable) begin
      // pwm stops with the analog side, pin then rests high
      next_p0_out[ppm_pkg::pwm_bit] = analog_run ? pwm_level : 1'b1;
    end
    if (mode == ppm_pkg::ppm_prog) next_p0_oe_n = 5'h1f;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      p0_out <= 5'h00;
      p0_oe_n <= 5'h1f;
      p0_read <= 5'h00;
    end else begin
      p0_out <= next_p0_out;
      p0_oe_n <= next_p0_oe_n;
      p0_read <= p0_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      p1_out <= 8'h00;
      p1_oe_n <= 8'hff;
      p1_read <= 8'h00;
    end else begin
      p1_out <= next_p1_out;
      p1_oe_n <= next_p1_oe_n;
      p1_read <= next_p1_read;
    end
  end

  // port 3 floats in programming so the address can come in
  always_ff @(posedge clk) begin
    if (rst) begin
      p3_out <= 8'h00;
      p3_oe_n <= 8'hff;
      p3_read <= 8'h00;
    end else begin
      p3_out <= p3_latch;
      p3_oe_n <= (mode == ppm_pkg::ppm_prog) ? 8'hff : 8'h00;
      p3_read <= p3_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // alternate inputs; idle keeps them alive
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq0_in <= 1'b1;
      ext_irq1_in <= 1'b1;
      timer_zero_count_in <= 1'b0;
    end else begin
      ext_irq0_in <= irq0_enable ? p1_s[ppm_pkg::irq0_bit] : 1'b1;
      ext_irq1_in <= irq1_enable ? p1_s[ppm_pkg::irq1_bit] : 1'b1;
      timer_zero_count_in <= count_enable && p1_s[ppm_pkg::count_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // programming address and data capture
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_d <= 1'b0;
    end else begin
      prog_d <= mode == ppm_pkg::ppm_prog;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_addr <= 8'h00;
      high_addr <= 3'h0;
    end else begin
      if (mode == ppm_pkg::ppm_prog) begin
        if (!p0_s[ppm_pkg::sel_bit]) low_addr <= p3_s;
        else high_addr <= p3_s[ppm_pkg::high_addr_bits-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_addr <= 11'h000;
      prog_wdata <= 8'h00;
      prog_write <= 1'b0;
    end else begin
      prog_addr <= {high_addr, low_addr};
      prog_wdata <= p1_s;
      prog_write <= prog_d && !p0_s[ppm_pkg::oe_bit];
    end
  end
endmodule : ppm_top

// ===== verif/ppm_chk.sv
`timescale 1ns/100ps
module ppm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic [4:0] p0_in,
  input wire logic [4:0] p0_out,
  input wire logic [4:0] p0_oe_n,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe_n,
  input wire logic p3_wr,
  input wire logic [7:0] p3_wdata,
  input wire logic adc_enable,
  input wire logic irq0_enable,
  input wire logic irq_pending,
  input wire logic [7:0] mem_rdata,
  input wire logic ext_irq0_in,
  input wire logic prog_mode,
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic analog_run,
  input wire logic osc_run,
  input wire logic internal_clock,
  input wire logic device_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // six cycles cover pin sync plus output register
  sequence s_verify_held;
    (prog_mode && p0_in[1] && $stable(mem_rdata)) [*6];
  endsequence
  sequence s_asleep;
    !cpu_run && !prog_mode && !device_reset && !$past(device_reset);
  endsequence
  a_open_drain_low: assert property ((p0_out[2:0] & ~p0_oe_n[2:0]) == 3'h0)
    else $error("open drain pin driven high");
  a_analog_no_drive: assert property (
    adc_enable && $past(adc_enable) && !prog_mode |-> p1_oe_n[4:0] == 5'h1f)
    else $error("analog pin drives while converter on");
  a_irq_idle_high: assert property (
    !irq0_enable && !$past(irq0_enable) && !$past(rst) |-> ext_irq0_in)
    else $error("unused interrupt input not idle high");
  a_clock_halves: assert property (
    $changed(internal_clock) |=> $stable(internal_clock) [*2])
    else $error("internal clock toggles faster than crystal half rate");
  a_idle_stops_analog: assert property (
    !cpu_run && periph_run && !prog_mode |-> !analog_run)
    else $error("converter runs during idle");
  a_down_holds: assert property (
    !osc_run && irq_pending && !reset_pin && !device_reset && !$past(device_reset)
    |=> !osc_run)
    else $error("power-down left without reset");
  // latch takes the write, pin register shows it one edge later
  a_latch_write: assert property (
    p3_wr && cpu_run && !prog_mode && !device_reset
    |=> ##1 p3_out == $past(p3_wdata, 2) && p3_oe_n == 8'h00)
    else $error("port 3 latch write not on pins");
  a_sleep_keeps: assert property (
    s_asleep |=> device_reset || prog_mode || ($stable(p3_out) && $stable(p3_oe_n)))
    else $error("port data changed while asleep");
  a_verify_drive: assert property (
    s_verify_held |-> p1_oe_n == 8'h00 && p1_out == mem_rdata)
    else $error("verify data not driven on port 1");
endmodule : ppm_chk
////////////////////////////////////////////////////////////////
bind ppm_top ppm_chk u_chk (.clk, .rst, .reset_pin, .p0_in, .p0_out, .p0_oe_n,
  .p1_out, .p1_oe_n, .p3_out, .p3_oe_n, .p3_wr, .p3_wdata, .adc_enable,
  .irq0_enable, .irq_pending, .mem_rdata, .ext_irq0_in, .prog_mode, .cpu_run,
  .periph_run, .analog_run, .osc_run, .internal_clock, .device_reset);

// ===== verif/ppm_board.sv
`timescale 1ns/100ps
module ppm_board (
  input wire logic go,
  input wire logic hold,
  input wire logic [9:0] code,
  input wire logic [10:0] addr,
  input wire logic sel,
  input wire logic [10:0] prog_addr,
  output logic crystal_in,
  output logic reset_pin,
  output logic [7:0] p3_prog,
  output logic [7:0] mem_rdata
);
  logic sbit = 1'b0;
  // external clock source: runs free, not framed
  initial begin
    crystal_in = 1'b0;
    forever #30 crystal_in = ~crystal_in;
  end
  // pin has a pull-down, so it rests low
  assign reset_pin = hold | sbit;
  // unused high part bits carry junk on purpose
  assign p3_prog = sel ? {5'h15, addr[10:8]} : addr[7:0];
  assign mem_rdata = prog_addr[7:0] ^ 8'h5a;
  always @(posedge go) begin
    for (int i = 0; i < 10; i++) begin
      @(negedge crystal_in);
      sbit = code[i];
    end
    @(negedge crystal_in);
    sbit = 1'b0;
  end
endmodule : ppm_board

// ===== verif/tb_port_pins_power_modes.sv
`timescale 1ns/100ps
module tb_port_pins_power_modes;
  localparam logic [9:0] code = 10'h1b3;
  logic clk, rst, go, hold, prog_on, p0_wr, p1_wr, p3_wr, pwm_enable, pwm_level;
  logic adc_enable, irq0_enable, irq1_enable, count_enable, crystal_in, reset_pin;
  logic idle_request, down_request, irq_pending, ext_irq0_in, ext_irq1_in;
  logic timer_zero_count_in, prog_write, prog_mode, cpu_run, periph_run;
  logic analog_run, osc_run, internal_clock, device_reset;
  logic [2:0] adc_channel;
  logic [4:0] p0_in, p0_out, p0_oe_n, p0_wdata, p0_read;
  logic [7:0] p1_val, p3_val, p1_in, p1_out, p1_oe_n, p1_wdata, p1_read, p3_in;
  logic [7:0] p3_out, p3_oe_n, p3_wdata, p3_read, p3_prog, mem_rdata, prog_wdata;
  logic [10:0] addr, prog_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  // pull-up pins: wired-and of driver and board
  assign p1_in = p1_val & (p1_out | p1_oe_n);
  assign p3_in = prog_on ? p3_prog : p3_val & (p3_out | p3_oe_n);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ppm_top #(.entry_code(code), .reset_clocks(24)) u_dut (.clk, .rst, .crystal_in,
    .reset_pin, .p0_in, .p0_out, .p0_oe_n, .p1_in, .p1_out, .p1_oe_n, .p3_in,
    .p3_out, .p3_oe_n, .p0_wr, .p0_wdata, .p1_wr, .p1_wdata, .p3_wr, .p3_wdata,
    .p0_read, .p1_read, .p3_read, .adc_enable, .adc_channel, .pwm_enable,
    .pwm_level, .irq0_enable, .irq1_enable, .count_enable, .idle_request,
    .down_request, .irq_pending, .mem_rdata, .ext_irq0_in, .ext_irq1_in,
    .timer_zero_count_in, .prog_addr, .prog_wdata, .prog_write, .prog_mode,
    .cpu_run, .periph_run, .analog_run, .osc_run, .internal_clock, .device_reset);
  ppm_board u_board (.go, .hold, .code, .addr, .sel(p0_in[0]), .prog_addr,
    .crystal_in, .reset_pin, .p3_prog, .mem_rdata);
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    {p3_wr, p1_wr, p0_wr} = s;
    {p0_wdata, p1_wdata, p3_wdata} = {d[4:0], d, d};
    tick(1);
    {p3_wr, p1_wr, p0_wr} = 3'h0;
    // pin register follows the latch one edge later; also spaces writes
    tick(1);
  endtask : wr
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    #50us;
    n_mismatch++;
    results();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, go, hold, prog_on, p0_wr, p1_wr, p3_wr, pwm_enable, pwm_level} = 9'h100;
    {adc_enable, irq0_enable, irq1_enable, count_enable} = 4'h0;
    {idle_request, down_request, irq_pending, adc_channel, addr} = 17'h0;
    {p0_in, p1_val, p3_val} = 21'h1fffff;
    tick(20);
    rst = 1'b0;
    tick(4);
    wr(3'h7, 8'h1a);
    chk("p3_out", 8'h1a, p3_out);
    chk("p0_oe_n", 5'h02, p0_oe_n);
    chk("p0_out_pu", 2'h3, p0_out[4:3]);
    chk("p0_read", 5'h1f, p0_read);
    wr(3'h6, 8'hff);
    p3_val = 8'h3c;
    tick(5);
    chk("p3_read", 8'h3c, p3_read);
    // converter enabled long after reset, references settled by then
    {adc_enable, adc_channel} = 4'ha;
    tick(6);
    chk("p1_read_an", 8'hfb, p1_read);
    chk("p1_oe_n_an", 5'h1f, p1_oe_n[4:0]);
    adc_enable = 1'b0;
    tick(3);
    chk("p1_oe_n_off", 8'h00, p1_oe_n);
    {irq0_enable, irq1_enable, count_enable} = 3'h7;
    for (int i = 0; i < 2; i++) begin
      p1_val = i ? 8'hbf : 8'h5f;
      tick(6);
      chk("alt_in", i ? 3'h5 : 3'h2, {timer_zero_count_in, ext_irq1_in, ext_irq0_in});
    end
    {irq0_enable, irq1_enable, count_enable} = 3'h0;
    tick(5);
    chk("alt_off", 2'h3, {ext_irq1_in, ext_irq0_in});
    chk("p1_read_alt", 3'h5, p1_read[7:5]);
    {pwm_enable, pwm_level} = 2'h2;
    tick(3);
    chk("pwm_lo", 2'h0, {p0_out[4], p0_oe_n[4]});
    pwm_level = 1'b1;
    tick(3);
    chk("pwm_hi", 1'b1, p0_out[4]);
    pwm_enable = 1'b0;
    wr(3'h1, 8'h0f);
    tick(2);
    chk("p0_bit4", 1'b0, p0_out[4]);
    idle_request = 1'b1;
    tick(1);
    idle_request = 1'b0;
    tick(3);
    chk("idle_runs", 3'h2, {cpu_run, periph_run, analog_run});
    wr(3'h4, 8'h00);
    tick(1);
    chk("p3_idle", 8'hff, p3_out);
    irq_pending = 1'b1;
    tick(4);
    chk("wake_irq", 1'b1, cpu_run);
    irq_pending = 1'b0;
    down_request = 1'b1;
    tick(1);
    down_request = 1'b0;
    irq_pending = 1'b1;
    tick(6);
    chk("down_osc", 2'h0, {osc_run, cpu_run});
    chk("p3_down", 8'hff, p3_out);
    irq_pending = 1'b0;
    hold = 1'b1;
    tick(250);
    chk("pin_reset", 1'b1, device_reset);
    hold = 1'b0;
    for (int k = 0; k < 100 && device_reset !== 1'b0; k++) tick(1);
    chk("osc_back", 2'h3, {osc_run, p0_out[4]});
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (int k = 0; k < 300 && prog_mode !== 1'b1; k++) tick(1);
    chk("prog_mode", 1'b1, prog_mode);
    {prog_on, addr, p0_in} = {1'b1, 11'h5c3, 5'h04};
    tick(6);
    chk("addr_lo", 8'hc3, prog_addr[7:0]);
    p0_in = 5'h05;
    p1_val = 8'h3c;
    tick(6);
    chk("addr_hi", 3'h5, prog_addr[10:8]);
    chk("prog_data", 9'h13c, {prog_write, prog_wdata});
    p0_in = 5'h07;
    tick(6);
    chk("verify", 16'h0099, {p1_oe_n, p1_out});
    results();
  end
endmodule : tb_port_pins_power_modes
